// ---- src/tsh_pkg.sv ----
/*
  Shared constants and carrier types for the two-wire target interface
  with high-speed mode and clock-low timeout.
  Assumes a 100 MHz core clock and a free-running link sampling clock.
*/
package tsh_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int TIMEOUT_MS     = 30;
  localparam int TIMEOUT_CYC    = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int TMO_W          = 22;
  localparam int LINK_PERIOD_PS = 6000;
  localparam int FS_FILT_NS     = 50;
  localparam int HS_FILT_NS     = 10;
  localparam int FS_FILT_RAW    = FS_FILT_NS * 1000 / LINK_PERIOD_PS;
  localparam int HS_FILT_RAW    = HS_FILT_NS * 1000 / LINK_PERIOD_PS;
  localparam logic [3:0] FS_FILT_CYC =
    (FS_FILT_RAW < 1) ? 4'h1 : 4'(FS_FILT_RAW);
  localparam logic [3:0] HS_FILT_CYC =
    (HS_FILT_RAW < 1) ? 4'h1 : 4'(HS_FILT_RAW);

  // ----------------------------------------------------------------
  // Bus codes and pin indices
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE  = 7'h48;
  localparam logic [4:0] HS_PFX     = 5'h01;
  localparam logic [7:0] GC_ADDR    = 8'h00;
  localparam logic [7:0] INIT_CMD   = 8'h06;
  localparam logic [7:0] PTR_RST    = 8'h00;
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  localparam int         PIN_SCL    = 0;
  localparam int         PIN_SDA    = 1;
  localparam int         PIN_A0     = 2;
  localparam int         PIN_A1     = 3;
  localparam int         NPIN       = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_RX   = 7'h08,
    ST_RACK = 7'h10,
    ST_TX   = 7'h20,
    ST_TCHK = 7'h40
  } tsh_state_type;

  typedef enum logic [1:0] {
    EV_NONE = 2'h0,
    EV_PTR  = 2'h1,
    EV_WORD = 2'h2,
    EV_INIT = 2'h3
  } tsh_evk_type;

  typedef struct packed {
    tsh_evk_type kind;
    logic [15:0] data;
  } tsh_ev_type;

endpackage

// ---- src/tsh_pin_filt.sv ----
/*
  Pin conditioner: two-flop synchroniser followed by a glitch filter
  whose length can change on the fly.
  Assumes the pin is asynchronous to clk_in and len_in is at least one.
*/
`timescale 1ns/1ps
module tsh_pin_filt
  import tsh_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Pin and filter length
  input  wire logic       pin_in,
  input  wire logic [3:0] len_in,
  // Conditioned level
  output logic            q_out
);

  logic       s1_r;
  logic       s2_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       q_r;
  logic       q_nxt;

  // ----------------------------------------------------------------
  // Filter: output follows only after len_in agreeing samples
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt = 4'h0;
    q_nxt   = q_r;
    if (s2_r != q_r) begin
      if (cnt_r + 4'h1 >= len_in) begin
        q_nxt = s2_r;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  // Resting level is high, as on an idle pulled-up bus
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_r  <= 1'b1;
      s2_r  <= 1'b1;
      cnt_r <= 4'h0;
      q_r   <= 1'b1;
    end else begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      cnt_r <= cnt_nxt;
      q_r   <= q_nxt;
    end
  end

  assign q_out = q_r;

endmodule

// ---- src/tsh_i2c_target.sv ----
/*
  Two-wire bus target: START/STOP, addressing, high-speed entry, word
  reads and writes through a retained pointer, and clock-low timeout.
  Assumes link_clk_in runs free and fast enough to oversample the bus;
  the register file sits outside on clk_in and answers rd_data_in.
*/
// Functional notes
// - Bus runs up to 400kHz; command 00001xxx after START allows 3.4MHz.
// - High-speed command is not acknowledged; clock and data filters switch to short length.
// - High-speed mode persists across transfers until a STOP or a timeout.
// - STOP returns the filters to their long, slow-rate length.
// - Initialization command 06 is recognised; address acquire is refused.
// - Interface resets when the clock stays low for about 30ms.
// - Timeout releases the data line if it was held low.
// - After timeout the target ignores the bus until a fresh START.
// - Data falling while clock high is START; START precedes transfers.
// - Data rising while clock high is STOP; START or STOP abandons transfer.
// - Any number of bytes may be exchanged between START and STOP.
// - START or STOP after the high byte ends a read cleanly.
// - Own address is acknowledged by holding data low through high phase.
// - Not-acknowledge after a read byte makes the target release data.
// - Idle bus is undriven by both parties; pull-ups hold it high.
// - Target answers one of addresses 0x48 to 0x4B from the select pin.
// - First written byte loads the pointer; later accesses use it.
// - Words move as two bytes, high byte first, MSB first.
`timescale 1ns/1ps
module tsh_i2c_target
  import tsh_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC_P = TIMEOUT_CYC
) (
  // Core clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // Link sampling clock
  input  wire logic        link_clk_in,
  // Bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic [1:0]  address_select_pin,
  // Register file side
  input  wire logic [15:0] rd_data_in,
  output logic [7:0]       ptr_out,
  output logic [15:0]      wr_data_out,
  output logic             wr_strobe_out,
  output logic             init_out,
  output logic             hs_mode_out,
  output logic             timeout_out
);

  typedef struct packed {
    tsh_state_type state;
    logic [7:0]    shift;
    logic [3:0]    cnt;
    logic          first;
    logic          rw;
    logic          gc;
    logic          ptr_ph;
    logic          hi_ph;
    logic          ack_ok;
    logic          hs;
    logic          sda_oe;
    logic [7:0]    tx_sh;
    logic [15:0]   tx_word;
    logic          tx_lo;
    logic [7:0]    wbuf;
    logic          ev_tgl;
    tsh_ev_type    ev;
    logic          rd_tgl;
    logic          scl_q;
    logic          sda_q;
  } tsh_lnk_type;

  typedef struct packed {
    logic             scl_s1;
    logic             scl_s2;
    logic [TMO_W-1:0] tmo_cnt;
    logic             tmo_tgl;
    logic             ev_s1;
    logic             ev_s2;
    logic             ev_q;
    logic             rq_s1;
    logic             rq_s2;
    logic             rq_q;
    logic [15:0]      rd_hold;
    logic             ack_tgl;
    logic             hs_s1;
    logic             hs_s2;
    logic [7:0]       ptr;
    logic [15:0]      wdata;
    logic             wstb;
    logic             init;
    logic             tmo;
  } tsh_cor_type;

  localparam logic [TMO_W-1:0] TMO_LIM = TMO_W'(TIMEOUT_CYC_P);

  tsh_lnk_type     l_r;
  tsh_lnk_type     l_nxt;
  tsh_cor_type     c_r;
  tsh_cor_type     c_nxt;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_f;
  logic [3:0]      bus_len;
  logic            scl_f;
  logic            sda_f;
  logic [6:0]      own_addr;
  logic            start_w;
  logic            stop_w;
  logic            rise_w;
  logic            fall_w;
  logic            tmo_s1_r;
  logic            tmo_s2_r;
  logic            tmo_q_r;
  logic            ack_s1_r;
  logic            ack_s2_r;
  logic            ack_q_r;
  logic            sda_lo_r;
  logic            tmo_edge;
  logic            ack_edge;

  // ----------------------------------------------------------------
  // Pin conditioning on the link clock
  // ----------------------------------------------------------------
  // Short filters only while high-speed mode is on
  assign bus_len = l_r.hs ? HS_FILT_CYC : FS_FILT_CYC;
  assign pin_raw = {address_select_pin, sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      tsh_pin_filt u_filt (
        .clk_in     (link_clk_in),
        .reset_n_in (reset_n_in),
        .pin_in     (pin_raw[gi]),
        .len_in     ((gi < PIN_A0) ? bus_len : FS_FILT_CYC),
        .q_out      (pin_f[gi])
      );
    end
  endgenerate

  assign scl_f    = pin_f[PIN_SCL];
  assign sda_f    = pin_f[PIN_SDA];
  assign own_addr = {ADDR_BASE[6:2], pin_f[PIN_A1], pin_f[PIN_A0]};
  assign start_w  = scl_f & l_r.scl_q & l_r.sda_q & ~sda_f;
  assign stop_w   = scl_f & l_r.scl_q & ~l_r.sda_q & sda_f;
  assign rise_w   = scl_f & ~l_r.scl_q;
  assign fall_w   = ~scl_f & l_r.scl_q;
  assign tmo_edge = tmo_s2_r ^ tmo_q_r;
  assign ack_edge = ack_s2_r ^ ack_q_r;

  // ----------------------------------------------------------------
  // Crossings into the link domain
  // ----------------------------------------------------------------
  // Toggles only; the read word is held still until the next request
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tmo_s1_r <= 1'b0;
      tmo_s2_r <= 1'b0;
      tmo_q_r  <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_q_r  <= 1'b0;
      sda_lo_r <= 1'b0;
    end else begin
      tmo_s1_r <= c_r.tmo_tgl;
      tmo_s2_r <= tmo_s1_r;
      tmo_q_r  <= tmo_s2_r;
      ack_s1_r <= c_r.ack_tgl;
      ack_s2_r <= ack_s1_r;
      ack_q_r  <= ack_s2_r;
      sda_lo_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  always_comb begin
    l_nxt       = l_r;
    l_nxt.scl_q = scl_f;
    l_nxt.sda_q = sda_f;
    if (ack_edge) begin
      l_nxt.tx_word = c_r.rd_hold;
    end
    case (l_r.state)
      ST_IDLE: begin
        l_nxt.sda_oe = 1'b0;
      end
      ST_ADDR: begin
        if (rise_w) begin
          l_nxt.shift = {l_r.shift[6:0], sda_f};
          l_nxt.cnt   = l_r.cnt + 4'h1;
        end
        if (fall_w && l_r.cnt == BITS_BYTE) begin
          l_nxt.first = 1'b0;
          l_nxt.cnt   = 4'h0;
          if (l_r.first && l_r.shift[7:3] == HS_PFX) begin
            l_nxt.hs    = 1'b1;
            l_nxt.state = ST_IDLE;
          end else if (l_r.shift[7:1] == own_addr) begin
            l_nxt.rw     = l_r.shift[0];
            l_nxt.sda_oe = 1'b1;
            l_nxt.state  = ST_AACK;
            if (l_r.shift[0]) begin
              l_nxt.rd_tgl = ~l_r.rd_tgl;
            end
          end else if (l_r.shift == GC_ADDR) begin
            l_nxt.gc     = 1'b1;
            l_nxt.rw     = 1'b0;
            l_nxt.sda_oe = 1'b1;
            l_nxt.state  = ST_AACK;
          end else begin
            l_nxt.state = ST_IDLE;
          end
        end
      end
      ST_AACK: begin
        if (fall_w) begin
          if (l_r.rw) begin
            l_nxt.tx_sh  = l_r.tx_word[15:8];
            l_nxt.tx_lo  = 1'b1;
            l_nxt.sda_oe = ~l_r.tx_word[15];
            l_nxt.cnt    = 4'h1;
            l_nxt.state  = ST_TX;
          end else begin
            l_nxt.sda_oe = 1'b0;
            l_nxt.state  = ST_RX;
          end
        end
      end
      ST_RX: begin
        if (rise_w) begin
          l_nxt.shift = {l_r.shift[6:0], sda_f};
          l_nxt.cnt   = l_r.cnt + 4'h1;
        end
        if (fall_w && l_r.cnt == BITS_BYTE) begin
          l_nxt.cnt    = 4'h0;
          l_nxt.sda_oe = 1'b1;
          l_nxt.state  = ST_RACK;
          if (l_r.gc) begin
            if (l_r.shift == INIT_CMD) begin
              l_nxt.ev     = '{EV_INIT, 16'h0000};
              l_nxt.ev_tgl = ~l_r.ev_tgl;
            end else begin
              l_nxt.sda_oe = 1'b0;
              l_nxt.state  = ST_IDLE;
            end
          end else if (l_r.ptr_ph) begin
            l_nxt.ptr_ph = 1'b0;
            l_nxt.ev     = '{EV_PTR, {8'h00, l_r.shift}};
            l_nxt.ev_tgl = ~l_r.ev_tgl;
          end else if (l_r.hi_ph) begin
            l_nxt.hi_ph = 1'b0;
            l_nxt.wbuf  = l_r.shift;
          end else begin
            l_nxt.hi_ph  = 1'b1;
            l_nxt.ev     = '{EV_WORD, {l_r.wbuf, l_r.shift}};
            l_nxt.ev_tgl = ~l_r.ev_tgl;
          end
        end
      end
      ST_RACK: begin
        if (fall_w) begin
          l_nxt.sda_oe = 1'b0;
          l_nxt.state  = ST_RX;
        end
      end
      ST_TX: begin
        if (fall_w) begin
          if (l_r.cnt == BITS_BYTE) begin
            l_nxt.sda_oe = 1'b0;
            l_nxt.ack_ok = 1'b0;
            l_nxt.state  = ST_TCHK;
          end else begin
            l_nxt.tx_sh  = {l_r.tx_sh[6:0], 1'b0};
            l_nxt.sda_oe = ~l_r.tx_sh[6];
            l_nxt.cnt    = l_r.cnt + 4'h1;
          end
        end
      end
      ST_TCHK: begin
        if (rise_w) begin
          if (sda_f) begin
            l_nxt.state = ST_IDLE;
          end else begin
            l_nxt.ack_ok = 1'b1;
          end
        end
        if (fall_w && l_r.ack_ok) begin
          // Bytes alternate high, low for as long as reads are acked
          l_nxt.tx_sh  = l_r.tx_lo ? l_r.tx_word[7:0] : l_r.tx_word[15:8];
          l_nxt.sda_oe = l_r.tx_lo ? ~l_r.tx_word[7] : ~l_r.tx_word[15];
          l_nxt.tx_lo  = ~l_r.tx_lo;
          l_nxt.cnt    = 4'h1;
          l_nxt.state  = ST_TX;
        end
      end
      default: begin
        l_nxt.state  = ST_IDLE;
        l_nxt.sda_oe = 1'b0;
      end
    endcase
    if (stop_w) begin
      l_nxt.state  = ST_IDLE;
      l_nxt.sda_oe = 1'b0;
      l_nxt.hs     = 1'b0;
    end
    if (start_w) begin
      l_nxt.state  = ST_ADDR;
      l_nxt.sda_oe = 1'b0;
      l_nxt.cnt    = 4'h0;
      l_nxt.first  = 1'b1;
      l_nxt.gc     = 1'b0;
      l_nxt.ptr_ph = 1'b1;
      l_nxt.hi_ph  = 1'b1;
    end
    // Timeout wins: a stuck clock must never keep data held low
    if (tmo_edge) begin
      l_nxt.state  = ST_IDLE;
      l_nxt.sda_oe = 1'b0;
      l_nxt.hs     = 1'b0;
    end
  end

  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      l_r         <= '0;
      l_r.state   <= ST_IDLE;
      l_r.ptr_ph  <= 1'b1;
      l_r.hi_ph   <= 1'b1;
      l_r.scl_q   <= 1'b1;
      l_r.sda_q   <= 1'b1;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: timeout, event capture, read snapshot
  // ----------------------------------------------------------------
  always_comb begin
    c_nxt        = c_r;
    c_nxt.wstb   = 1'b0;
    c_nxt.init   = 1'b0;
    c_nxt.tmo    = 1'b0;
    c_nxt.scl_s1 = scl_in;
    c_nxt.scl_s2 = c_r.scl_s1;
    c_nxt.ev_s1  = l_r.ev_tgl;
    c_nxt.ev_s2  = c_r.ev_s1;
    c_nxt.ev_q   = c_r.ev_s2;
    c_nxt.rq_s1  = l_r.rd_tgl;
    c_nxt.rq_s2  = c_r.rq_s1;
    c_nxt.rq_q   = c_r.rq_s2;
    c_nxt.hs_s1  = l_r.hs;
    c_nxt.hs_s2  = c_r.hs_s1;
    // Saturating count fires once per low stretch
    if (c_r.scl_s2) begin
      c_nxt.tmo_cnt = '0;
    end else if (c_r.tmo_cnt < TMO_LIM) begin
      c_nxt.tmo_cnt = c_r.tmo_cnt + TMO_W'(1);
      if (c_r.tmo_cnt + TMO_W'(1) == TMO_LIM) begin
        c_nxt.tmo_tgl = ~c_r.tmo_tgl;
        c_nxt.tmo     = 1'b1;
      end
    end
    if (c_r.ev_s2 ^ c_r.ev_q) begin
      case (l_r.ev.kind)
        EV_PTR: c_nxt.ptr = l_r.ev.data[7:0];
        EV_WORD: begin
          c_nxt.wdata = l_r.ev.data;
          c_nxt.wstb  = 1'b1;
        end
        EV_INIT: begin
          c_nxt.ptr  = PTR_RST;
          c_nxt.init = 1'b1;
        end
        default: c_nxt.init = 1'b0;
      endcase
    end
    if (c_r.rq_s2 ^ c_r.rq_q) begin
      c_nxt.rd_hold = rd_data_in;
      c_nxt.ack_tgl = ~c_r.ack_tgl;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      c_r        <= '0;
      c_r.scl_s1 <= 1'b1;
      c_r.scl_s2 <= 1'b1;
      c_r.ptr    <= PTR_RST;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign sda_out       = sda_lo_r;
  assign sda_oe_out    = l_r.sda_oe;
  assign ptr_out       = c_r.ptr;
  assign wr_data_out   = c_r.wdata;
  assign wr_strobe_out = c_r.wstb;
  assign init_out      = c_r.init;
  assign hs_mode_out   = c_r.hs_s2;
  assign timeout_out   = c_r.tmo;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_hs_cmd;
    l_r.state == ST_ADDR && fall_w && l_r.cnt == BITS_BYTE &&
      l_r.first && l_r.shift[7:3] == HS_PFX && !start_w && !stop_w &&
      !tmo_edge;
  endsequence
  sequence s_hs_on;
    !l_r.sda_oe && l_r.hs && l_r.state == ST_IDLE;
  endsequence
  property p_hs_nack;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      s_hs_cmd |=> s_hs_on ##1 (bus_len == HS_FILT_CYC);
  endproperty
  a_hs_nack: assert property (p_hs_nack)
    else $error("high-speed command acked or mode not entered");

  property p_stop_slow;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      stop_w |=> !l_r.hs && bus_len == FS_FILT_CYC && !l_r.sda_oe;
  endproperty
  a_stop_slow: assert property (p_stop_slow)
    else $error("STOP did not restore slow filters");

  property p_start_addr;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      start_w && !tmo_edge |=> l_r.state == ST_ADDR && l_r.cnt == 4'h0;
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("START not followed by address phase");

  property p_ack_hold;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      l_r.state == ST_AACK && scl_f |-> l_r.sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("address ack released during clock high");

  property p_nack_end;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      l_r.state == ST_TCHK && rise_w && sda_f && !start_w
        |=> l_r.state == ST_IDLE ##1 !l_r.sda_oe;
  endproperty
  a_nack_end: assert property (p_nack_end)
    else $error("not-acknowledge did not end the read");

  property p_tmo_release;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      tmo_edge |=> l_r.state == ST_IDLE && !l_r.sda_oe;
  endproperty
  a_tmo_release: assert property (p_tmo_release)
    else $error("timeout did not release data");

  property p_idle_quiet;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      l_r.state == ST_IDLE && !start_w |=> !l_r.sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("data driven while idle");

  property p_tmo_restart;
    @(posedge clk_in) disable iff (!reset_n_in)
      c_r.scl_s2 |=> c_r.tmo_cnt == '0 && !c_r.tmo;
  endproperty
  a_tmo_restart: assert property (p_tmo_restart)
    else $error("timeout count not restarted by high clock");

  property p_tmo_fire;
    @(posedge clk_in) disable iff (!reset_n_in)
      !c_r.scl_s2 && c_r.tmo_cnt + TMO_W'(1) == TMO_LIM
        |=> c_r.tmo && $changed(c_r.tmo_tgl);
  endproperty
  a_tmo_fire: assert property (p_tmo_fire)
    else $error("timeout not raised at limit");

  property p_ptr_load;
    @(posedge clk_in) disable iff (!reset_n_in)
      (c_r.ev_s2 ^ c_r.ev_q) && l_r.ev.kind == EV_PTR
        |=> ptr_out == $past(l_r.ev.data[7:0]) && !wr_strobe_out;
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer byte not loaded");

endmodule

// ---- tb/tsh_bus_ctl.sv ----
/*
  Behavioural two-wire bus controller: drives the clock, pulls data low.
  Assumes the bench resolves released lines high through pull-ups.
*/
`timescale 1ns/1ps
module tsh_bus_ctl #(
  parameter time Q = 630ns
) (
  // Bus lines, high means pulling low
  output logic      scl_low_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  // ----------------------------------------------------------------
  // Bus actions
  // ----------------------------------------------------------------
  // Both lines released at rest
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  // One bit; four quarters of 630 ns keep the rate below 400 kHz
  task automatic bit_io(input logic b, output logic s);
    sda_low_out = ~b;
    #Q scl_low_out = 1'b0;
    #Q s = sda_in;
    #Q scl_low_out = 1'b1;
    #Q;
  endtask
  // Data falls while clock high; also serves as repeated start
  task automatic start();
    sda_low_out = 1'b0;
    #Q scl_low_out = 1'b0;
    #Q sda_low_out = 1'b1;
    #Q scl_low_out = 1'b1;
    #Q;
  endtask
  // Data rises while clock high, then the bus rests
  task automatic stop();
    sda_low_out = 1'b1;
    #Q scl_low_out = 1'b0;
    #Q sda_low_out = 1'b0;
    #(2 * Q);
  endtask
  // Byte out, MSB first, any count per transfer; ack seen as low
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Byte in; leaving ack high ends the read
  task automatic rbyte(input logic a, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~a, s);
  endtask
endmodule

// ---- tb/tb.sv ----
/*
  Self-checking bench for the two-wire target with timeout.
  Assumes the controller model in tsh_bus_ctl and pull-ups on both lines.
*/
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [1:0]  sel;
    logic [7:0]  adw;
    logic        ack;
    logic [7:0]  ptr;
    logic [15:0] word;
  } tsh_row_type;
  logic        clk_in, reset_n_in, link_clk_in, scl_low, sda_low, ack;
  logic        sda_out, sda_oe_out, wr_strobe_out, init_out;
  logic        hs_mode_out, timeout_out, scl, sda;
  logic [1:0]  sel;
  logic [7:0]  ptr_out, rb;
  logic [15:0] wr_data_out, rd_word;
  int          bad_count = 0, n_compared = 0, n_wr = 0, n_init = 0, n_tmo = 0;
  tsh_row_type rows[5] = '{'{2'h0, 8'h92, 1'b0, 8'h01, 16'h1111},
    '{2'h0, 8'h90, 1'b1, 8'h01, 16'hbeef},
    '{2'h1, 8'h92, 1'b1, 8'h02, 16'h0001},
    '{2'h2, 8'h94, 1'b1, 8'h03, 16'h8000},
    '{2'h3, 8'h96, 1'b1, 8'hff, 16'ha55a}};
  // Wired-and of the open-drain lines with pull-ups
  assign scl = ~scl_low;
  assign sda = ~(sda_low | (sda_oe_out & ~sda_out));
  // Register file stand-in: the word read depends on the retained pointer
  assign rd_word = 16'h12a5 ^ {8'h00, ptr_out};
  tsh_i2c_target #(.TIMEOUT_CYC_P(200)) DUT (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .link_clk_in(link_clk_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .address_select_pin(sel), .rd_data_in(rd_word), .ptr_out(ptr_out),
    .wr_data_out(wr_data_out), .wr_strobe_out(wr_strobe_out),
    .init_out(init_out), .hs_mode_out(hs_mode_out),
    .timeout_out(timeout_out));
  tsh_bus_ctl ctl (.scl_low_out(scl_low), .sda_low_out(sda_low),
    .sda_in(sda));
  // Pulse counters, since strobes stand one cycle only
  always @(posedge clk_in) begin
    n_wr <= n_wr + int'(wr_strobe_out === 1'b1);
    n_init <= n_init + int'(init_out === 1'b1);
    n_tmo <= n_tmo + int'(timeout_out === 1'b1);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Clocks; link clock offset so the two never line up
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #1.7;
    forever #3 link_clk_in = ~link_clk_in;
  end
  // Hang guard, about 100k core cycles
  initial begin
    #1ms;
    bad_count++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0;
    sel = 2'h0;
    repeat (3) @(negedge clk_in);
    chk(16'(sda_oe_out), 16'h0);
    chk(16'(hs_mode_out), 16'h0);
    reset_n_in = 1'b1;
    repeat (30) @(negedge clk_in);
    foreach (rows[i]) begin
      sel = rows[i].sel;
      repeat (10) @(negedge clk_in);
      ctl.start();
      ctl.wbyte(rows[i].adw, ack);
      chk(16'(ack), 16'(rows[i].ack));
      if (rows[i].ack) begin
        ctl.wbyte(rows[i].ptr, ack);
        ctl.wbyte(rows[i].word[15:8], ack);
        ctl.wbyte(rows[i].word[7:0], ack);
        ctl.stop();
        chk(16'(ptr_out), 16'(rows[i].ptr));
        chk(wr_data_out, rows[i].word);
      end else begin
        ctl.stop();
      end
      chk(16'(n_wr), 16'(i));
    end
    chk(16'(n_tmo), 16'h0);
    // High-speed command refused, then kept across a repeated start
    ctl.start();
    ctl.wbyte(8'h0b, ack);
    chk(16'(ack), 16'h0);
    repeat (20) @(negedge clk_in);
    chk(16'(hs_mode_out), 16'h1);
    ctl.start();
    ctl.wbyte(8'h96, ack);
    chk(16'(ack), 16'h1);
    ctl.wbyte(8'h05, ack);
    ctl.start();
    chk(16'(hs_mode_out), 16'h1);
    ctl.stop();
    repeat (20) @(negedge clk_in);
    chk(16'(hs_mode_out), 16'h0);
    // Initialization command through the general call
    ctl.start();
    ctl.wbyte(8'h00, ack);
    ctl.wbyte(8'h06, ack);
    chk(16'(ack), 16'h1);
    ctl.stop();
    chk(16'(n_init), 16'h1);
    chk(16'(ptr_out), 16'h0);
    // Pointer write, then a three-byte read ending in not-acknowledge
    ctl.start();
    ctl.wbyte(8'h96, ack);
    ctl.wbyte(8'h0f, ack);
    ctl.start();
    ctl.wbyte(8'h97, ack);
    ctl.rbyte(1'b1, rb);
    chk(16'(rb), 16'h12);
    ctl.rbyte(1'b1, rb);
    chk(16'(rb), 16'haa);
    ctl.rbyte(1'b0, rb);
    chk(16'(rb), 16'h12);
    repeat (20) @(negedge clk_in);
    chk(16'(sda_oe_out), 16'h0);
    ctl.stop();
    // Repeated start right after the high byte of a read
    ctl.start();
    ctl.wbyte(8'h97, ack);
    ctl.rbyte(1'b1, rb);
    ctl.start();
    ctl.wbyte(8'h96, ack);
    chk(16'(ack), 16'h1);
    ctl.wbyte(8'h07, ack);
    ctl.stop();
    chk(16'(ptr_out), 16'h7);
    chk(16'(n_wr), 16'h4);
    // Clock held low while the target pulls data for the ack
    ctl.start();
    for (int k = 7; k >= 0; k--) begin
      ctl.bit_io(rows[4].adw[k], ack);
    end
    repeat (20) @(negedge clk_in);
    chk(16'(sda_oe_out), 16'h1);
    repeat (300) @(negedge clk_in);
    chk(16'(n_tmo), 16'h1);
    chk(16'(sda_oe_out), 16'h0);
    ctl.wbyte(8'h96, ack);
    chk(16'(ack), 16'h0);
    ctl.stop();
    ctl.start();
    ctl.wbyte(8'h96, ack);
    chk(16'(ack), 16'h1);
    ctl.stop();
    // Reset in mid-transfer while the target pulls data for the ack
    ctl.start();
    for (int k = 7; k >= 0; k--) begin
      ctl.bit_io(rows[4].adw[k], ack);
    end
    reset_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk(16'(sda_oe_out), 16'h0);
    chk(16'(ptr_out), 16'h0);
    reset_n_in = 1'b1;
    repeat (30) @(negedge clk_in);
    ctl.stop();
    ctl.start();
    ctl.wbyte(8'h96, ack);
    chk(16'(ack), 16'h1);
    ctl.stop();
    print_verdict();
  end
endmodule
